// file: rtl/cfl_ctrl.sv
// CAN acceptance filter, interrupt flags, config lock and low-power mode logic
//
// Operation
// - masked compare of received identifier bits against programmed acceptance code bits
// - on acceptance set receive-full flag and load the three-bit hit index
// - with several matches, the lowest-numbered filter is reported
// - two-filter mode: each 32-bit bank one filter, hits 0 and 1
// - four-filter mode: each 16-bit half bank one filter, hits 0 to 3
// - eight-filter mode: each byte matches first 8 id bits, hits 0 to 7
// - closed mode never loads foreground buffer nor sets receive-full
// - four interrupt outputs from eleven flags, each with its own enable
// - transmit interrupt when any enabled transmit-empty flag is set
// - receive interrupt right after end of frame of accepted loaded message
// - warning flags set when an error counter reaches 96
// - passive flags set when an error counter exceeds 127
// - bus-off flag set when transmit error counter exceeds 255
// - each interrupt stays asserted while any enabled flag stays set
// - flags clear only by writing one, not while the cause persists
// - error counters cannot be altered by any register access
// - config, timing and filter writes ignored unless soft reset set
// - transmit pin held recessive in every low-power mode
// - sleep/soft-reset gate engine clock; power-down stops all clocks
// - power-down from stop or wait+stop-in-wait; else sleep/soft-reset/normal
// - wake interrupt on bus activity in sleep when sleep-ack and enable set
// - overrun flagged and message dropped when both receive buffers full
// - sleep acknowledge held set while in sleep mode
// - no register accessible in power-down mode
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module cfl_ctrl #(
  parameter int ERR_W = 9                                  // error counter width
) (
  input  wire logic                       clk,             // 40 MHz controller clock
  input  wire logic                       rst_n,           // async reset, low
  input  wire logic [cfl_pkg::ADDR_W-1:0] avsAddress,      // word address
  input  wire logic                       avsRead,         // read request
  input  wire logic                       avsWrite,        // write request
  input  wire logic [31:0]                avsWriteData,    // write data, low byte used
  input  wire logic [3:0]                 avsByteEnable,   // byte lane 0 gates write
  output logic      [31:0]                avsReadData,     // read data
  output logic                            avsWaitRequest,  // stall until answer
  input  wire logic [31:0]                rxIdBits,        // received id/ctrl bits, bank layout
  input  wire logic                       rxFrameDone,     // pulse after end of frame
  input  wire logic                       rxOwnFrame,      // own frame, not loop-back
  input  wire logic                       bgBufFull,       // background buffer holds a message
  input  wire logic [ERR_W-1:0]           rxErrCount,      // receive error counter
  input  wire logic [ERR_W-1:0]           txErrCount,      // transmit error counter
  input  wire logic                       busActivity,     // bus activity seen
  input  wire logic                       sleepGranted,    // engine reached sleep
  input  wire logic [2:0]                 txEmptySet,      // engine releases tx buffers
  input  wire logic                       cpuStop,         // cpu in stop
  input  wire logic                       cpuWait,         // cpu in wait
  input  wire logic                       engineTx,        // engine transmit bit
  output logic                            canTxPin,        // bus pin, 1 recessive
  output logic                            engineClkEn,     // engine clock enable
  output logic                            regClkEn,        // register clock enable
  output logic                            fgLoad,          // copy background to foreground
  output logic                            wakeIrq,         // wake-up interrupt
  output logic                            errIrq,          // error interrupt
  output logic                            rxIrq,           // receive interrupt
  output logic                            txIrq            // transmit interrupt
);
  import cfl_pkg::*;

  if (ERR_W < 9) begin
    $error("ERR_W must hold 256");
  end

  logic [7:0] ctrl0Reg, ctrl0Next, ctrl1Reg, ctrl1Next;
  logic [7:0] timing0Reg, timing0Next, timing1Reg, timing1Next;
  logic [7:0] rxFlagReg, rxFlagNext, rxIenReg, rxIenNext;
  logic [2:0] txFlagReg, txFlagNext, txIenReg, txIenNext;
  logic [1:0] filtModeReg, filtModeNext;
  logic [AC_HIT_W-1:0] hitReg, hitNext;
  logic [7:0] codeReg [8], codeNext [8], maskReg [8], maskNext [8];
  logic [31:0] rdDataReg, rdDataNext;
  logic        ackReg, ackNext, waitReg, waitNext;
  logic        wakeIrqReg, errIrqReg, rxIrqReg, txIrqReg;
  logic        irqWakeNext, irqErrNext, irqRxNext, irqTxNext;
  logic        txPinReg, txPinNext, engClkReg, engClkNext, regClkReg, regClkNext;
  logic        fgLoadReg, fgLoadNext;
  cfl_pmode_t  pmode;

  // masked byte compare: mask one means don't care
  function automatic logic byteMatch(input logic [7:0] id, input logic [7:0] code,
                                     input logic [7:0] mask);
    return ((id ^ code) & ~mask) == 8'h00;
  endfunction

  always_comb begin
    if (cpuStop || (cpuWait && ctrl0Reg[MC0_STOP_WAIT]))
      pmode = MD_PWRDN;
    else if (ctrl0Reg[MC0_SLEEP_ACK] && !ctrl0Reg[MC0_SOFT_RESET])
      pmode = MD_SLEEP;
    else if (ctrl0Reg[MC0_SOFT_RESET])
      pmode = MD_SOFTRST;
    else
      pmode = MD_NORMAL;
  end

  // filter evaluation
  logic [7:0] byteHit;
  logic [3:0] halfHit;
  logic [1:0] bankHit;
  logic       anyHit;
  logic [AC_HIT_W-1:0] hitIdx;
  always_comb begin
    // masked compare per byte, banks share the same id layout
    for (int b = 0; b < 8; b++) begin
      byteHit[b] = byteMatch(rxIdBits[31-8*(b%4) -: 8], codeReg[b], maskReg[b]);
    end
    // every 16-bit filter looks at the leading 16 id bits
    for (int h = 0; h < 4; h++) begin
      halfHit[h] = byteMatch(rxIdBits[31:24], codeReg[2*h], maskReg[2*h])
                   && byteMatch(rxIdBits[23:16], codeReg[2*h+1], maskReg[2*h+1]);
    end
    for (int k = 0; k < 2; k++) begin
      bankHit[k] = &byteHit[4*k +: 4];
    end
    anyHit = 1'b0;
    hitIdx = '0;
    // lowest filter wins: scan downward so the last hit kept is lowest
    unique case (cfl_fmode_t'(filtModeReg))
      FM_TWO: begin
        for (int i = 1; i >= 0; i--) if (bankHit[i]) begin
          anyHit = 1'b1;
          hitIdx = AC_HIT_W'(i);
        end
      end
      FM_FOUR: begin
        for (int i = 3; i >= 0; i--) if (halfHit[i]) begin
          anyHit = 1'b1;
          hitIdx = AC_HIT_W'(i);
        end
      end
      FM_EIGHT: begin
        // 8-bit filters, first id byte only
        for (int i = 7; i >= 0; i--) begin
          if (byteMatch(rxIdBits[31:24], codeReg[i], maskReg[i])) begin
            anyHit = 1'b1;
            hitIdx = AC_HIT_W'(i);
          end
        end
      end
      FM_CLOSED: begin
        anyHit = 1'b0;
      end
    endcase
  end

  // bus access decode; power-down stalls every access
  logic busReq, wrEn, locked;
  always_comb begin
    busReq = (avsRead || avsWrite) && !ackReg && pmode != MD_PWRDN;
    wrEn   = busReq && avsWrite && avsByteEnable[0];
    locked = !ctrl0Reg[MC0_SOFT_RESET];
  end

  logic [7:0] wd;
  logic       accepted;
  always_comb begin
    wd = avsWriteData[7:0];
    ctrl0Next = ctrl0Reg;
    ctrl1Next = ctrl1Reg;
    timing0Next = timing0Reg;
    timing1Next = timing1Reg;
    rxIenNext = rxIenReg;
    txIenNext = txIenReg;
    filtModeNext = filtModeReg;
    hitNext = hitReg;
    codeNext = codeReg;
    maskNext = maskReg;
    rxFlagNext = rxFlagReg;
    txFlagNext = txFlagReg;
    fgLoadNext = 1'b0;
    if (wrEn) begin
      unique case (avsAddress)
        OFF_MODULE_CTRL0: begin
          ctrl0Next[MC0_SOFT_RESET] = wd[MC0_SOFT_RESET];
          ctrl0Next[MC0_SLEEP_REQ]  = wd[MC0_SLEEP_REQ];
          ctrl0Next[MC0_STOP_WAIT]  = wd[MC0_STOP_WAIT];
        end
        OFF_MODULE_CTRL1: if (!locked) ctrl1Next = wd;
        OFF_BIT_TIMING0:  if (!locked) timing0Next = wd;
        OFF_BIT_TIMING1:  if (!locked) timing1Next = wd;
        // mode field locked unless soft reset set
        OFF_ID_ACC_CTRL:  if (!locked) filtModeNext = wd[AC_MODE_LSB +: 2];
        OFF_RX_IRQ_EN:    rxIenNext = wd;
        OFF_TX_CTRL:      txIenNext = wd[2:0];
        OFF_RX_FLAG: rxFlagNext = rxFlagReg & ~wd;
        OFF_TX_FLAG: txFlagNext = txFlagReg & ~wd[2:0];
        default: begin
          if (!locked && avsAddress[4]) begin
            if (avsAddress[3]) maskNext[avsAddress[2:0]] = wd;
            else codeNext[avsAddress[2:0]] = wd;
          end
        end
      endcase
    end
    // sleep acknowledge follows the engine while requested
    ctrl0Next[MC0_SLEEP_ACK] = ctrl0Next[MC0_SLEEP_REQ] && sleepGranted
                               && !ctrl0Next[MC0_SOFT_RESET];
    // level conditions re-set the flag each cycle they hold
    if (rxErrCount >= ERR_W'(WARN_LIMIT) || txErrCount >= ERR_W'(WARN_LIMIT)) begin
      if (rxErrCount >= ERR_W'(WARN_LIMIT)) rxFlagNext[RF_RWRN] = 1'b1;
      if (txErrCount >= ERR_W'(WARN_LIMIT)) rxFlagNext[RF_TWRN] = 1'b1;
    end
    if (rxErrCount > ERR_W'(PASSIVE_LIMIT)) rxFlagNext[RF_RPAS] = 1'b1;
    if (txErrCount > ERR_W'(PASSIVE_LIMIT)) rxFlagNext[RF_TPAS] = 1'b1;
    if (txErrCount > ERR_W'(BUSOFF_LIMIT)) rxFlagNext[RF_BOFF] = 1'b1;
    // wake flag only in sleep with enable
    if (pmode == MD_SLEEP && busActivity && rxIenReg[RF_WAKE])
      rxFlagNext[RF_WAKE] = 1'b1;
    accepted = rxFrameDone && !rxOwnFrame && anyHit && pmode == MD_NORMAL;
    if (accepted) begin
      if (!rxFlagReg[RF_RXF]) begin
        // load foreground, set full and hit index
        rxFlagNext[RF_RXF] = 1'b1;
        hitNext = hitIdx;
        fgLoadNext = 1'b1;
      end else if (bgBufFull) begin
        // both buffers busy: overrun, message dropped
        rxFlagNext[RF_OVR] = 1'b1;
      end
    end
    // engine returns tx buffers; set wins over clear
    txFlagNext = txFlagNext | txEmptySet;
  end

  always_comb begin
    rdDataNext = rdDataReg;
    ackNext = busReq;
    waitNext = !busReq;
    if (busReq && avsRead) begin
      rdDataNext = 32'h0000_0000;
      unique case (avsAddress)
        OFF_MODULE_CTRL0: rdDataNext[7:0] = ctrl0Reg;
        OFF_MODULE_CTRL1: rdDataNext[7:0] = ctrl1Reg;
        OFF_BIT_TIMING0:  rdDataNext[7:0] = timing0Reg;
        OFF_BIT_TIMING1:  rdDataNext[7:0] = timing1Reg;
        OFF_RX_FLAG:      rdDataNext[7:0] = rxFlagReg;
        OFF_RX_IRQ_EN:    rdDataNext[7:0] = rxIenReg;
        OFF_TX_FLAG:      rdDataNext[2:0] = txFlagReg;
        OFF_TX_CTRL:      rdDataNext[2:0] = txIenReg;
        OFF_ID_ACC_CTRL:  rdDataNext[7:0] = {2'h0, filtModeReg, 1'b0, hitReg};
        OFF_ERR_COUNT:    rdDataNext = {7'h00, txErrCount[8:0], 7'h00, rxErrCount[8:0]};
        default: begin
          if (avsAddress[4]) rdDataNext[7:0] = avsAddress[3] ? maskReg[avsAddress[2:0]]
                                                             : codeReg[avsAddress[2:0]];
        end
      endcase
    end
  end

  always_comb begin
    // four outputs, each a level of its enabled flags
    irqWakeNext = rxFlagNext[RF_WAKE] && rxIenReg[RF_WAKE];
    irqErrNext  = |(rxFlagNext & rxIenReg & ERR_MASK);
    irqRxNext   = rxFlagNext[RF_RXF] && rxIenReg[RF_RXF];
    irqTxNext   = |(txFlagNext & txIenReg);
    txPinNext   = (pmode == MD_NORMAL) ? engineTx : 1'b1;
    engClkNext  = pmode == MD_NORMAL;
    regClkNext  = pmode != MD_PWRDN;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0Reg <= MC0_RESET;
      ctrl1Reg <= 8'h00;
      timing0Reg <= 8'h00;
      timing1Reg <= 8'h00;
      rxFlagReg <= 8'h00;
      rxIenReg <= 8'h00;
      txFlagReg <= TXE_RESET;
      txIenReg <= 3'h0;
      filtModeReg <= 2'h0;
      hitReg <= '0;
      for (int i = 0; i < 8; i++) begin
        codeReg[i] <= 8'h00;
        maskReg[i] <= 8'h00;
      end
      rdDataReg <= 32'h0000_0000;
      ackReg <= 1'b0;
      waitReg <= 1'b1;
      wakeIrqReg <= 1'b0;
      errIrqReg <= 1'b0;
      rxIrqReg <= 1'b0;
      txIrqReg <= 1'b0;
      txPinReg <= 1'b1;
      engClkReg <= 1'b0;
      regClkReg <= 1'b1;
      fgLoadReg <= 1'b0;
    end else begin
      ctrl0Reg <= ctrl0Next;
      ctrl1Reg <= ctrl1Next;
      timing0Reg <= timing0Next;
      timing1Reg <= timing1Next;
      rxFlagReg <= rxFlagNext;
      rxIenReg <= rxIenNext;
      txFlagReg <= txFlagNext;
      txIenReg <= txIenNext;
      filtModeReg <= filtModeNext;
      hitReg <= hitNext;
      codeReg <= codeNext;
      maskReg <= maskNext;
      rdDataReg <= rdDataNext;
      ackReg <= ackNext;
      waitReg <= waitNext;
      wakeIrqReg <= irqWakeNext;
      errIrqReg <= irqErrNext;
      rxIrqReg <= irqRxNext;
      txIrqReg <= irqTxNext;
      txPinReg <= txPinNext;
      engClkReg <= engClkNext;
      regClkReg <= regClkNext;
      fgLoadReg <= fgLoadNext;
    end
  end

  // waitrequest low exactly in the answer cycle
  assign avsWaitRequest = waitReg;
  assign avsReadData = rdDataReg;
  assign canTxPin = txPinReg;
  assign engineClkEn = engClkReg;
  assign regClkEn = regClkReg;
  assign fgLoad = fgLoadReg;
  assign wakeIrq = wakeIrqReg;
  assign errIrq = errIrqReg;
  assign rxIrq = rxIrqReg;
  assign txIrq = txIrqReg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_closed_no_rxf: assert property (
    (filtModeReg == 2'h3 && !rxFlagReg[RF_RXF]) ##1 (filtModeReg == 2'h3) |-> !rxFlagReg[RF_RXF])
    else $error("receive-full set in closed mode");
  chk_lock_timing: assert property (
    (wrEn && avsAddress == OFF_BIT_TIMING0 && locked) |=> $stable(timing0Reg))
    else $error("locked timing register changed");
  chk_tx_recessive: assert property (
    (pmode != MD_NORMAL) |=> canTxPin)
    else $error("transmit pin not recessive in low power");
  chk_pwrdn_stall: assert property (
    (pmode == MD_PWRDN && !ackReg) |=> avsWaitRequest)
    else $error("access answered in power-down");
  chk_busoff_set: assert property (
    (txErrCount > ERR_W'(BUSOFF_LIMIT)) |=> rxFlagReg[RF_BOFF])
    else $error("bus-off flag missing");
  chk_warn_set: assert property (
    (rxErrCount >= ERR_W'(WARN_LIMIT)) |=> rxFlagReg[RF_RWRN])
    else $error("rx warning flag missing");
  chk_tx_irq_level: assert property (
    (|(txFlagReg & txIenReg) && $stable(txIenReg) && txEmptySet == 3'h0 && !wrEn)
      |=> txIrq)
    else $error("transmit interrupt not raised");
  chk_accept_load: assert property (
    (accepted && !rxFlagReg[RF_RXF]) |=> (rxFlagReg[RF_RXF] && hitReg == $past(hitIdx) && fgLoad))
    else $error("accept did not load hit index");
  chk_overrun_set: assert property (
    (accepted && rxFlagReg[RF_RXF] && bgBufFull) |=> rxFlagReg[RF_OVR])
    else $error("overrun not flagged");
  chk_wake_gate: assert property (
    (!rxIenReg[RF_WAKE] && !rxFlagReg[RF_WAKE] && !wrEn) |=> !rxFlagReg[RF_WAKE])
    else $error("wake flag without enable");
  cov_accept: cover property (accepted && !rxFlagReg[RF_RXF]);
  cov_overrun: cover property (accepted && rxFlagReg[RF_RXF] && bgBufFull);
  cov_sleep: cover property (pmode == MD_SLEEP ##1 wakeIrq);
  cov_pwrdn: cover property (pmode == MD_PWRDN);
endmodule

// file: rtl/cfl_pkg.sv
// package: register map, field positions and mode codes of the CAN filter/irq/low-power block
package cfl_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_MODULE_CTRL0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_MODULE_CTRL1 = 5'h01;
  localparam logic [ADDR_W-1:0] OFF_BIT_TIMING0  = 5'h02;
  localparam logic [ADDR_W-1:0] OFF_BIT_TIMING1  = 5'h03;
  localparam logic [ADDR_W-1:0] OFF_RX_FLAG      = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_RX_IRQ_EN    = 5'h05;
  localparam logic [ADDR_W-1:0] OFF_TX_FLAG      = 5'h06;
  localparam logic [ADDR_W-1:0] OFF_TX_CTRL      = 5'h07;
  localparam logic [ADDR_W-1:0] OFF_ID_ACC_CTRL  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_ERR_COUNT    = 5'h09;
  localparam logic [ADDR_W-1:0] OFF_ACC_CODE0    = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_ACC_MASK0    = 5'h18;
  // module_ctrl0 bits
  localparam int MC0_SOFT_RESET = 0;
  localparam int MC0_SLEEP_REQ  = 1;
  localparam int MC0_SLEEP_ACK  = 4;
  localparam int MC0_STOP_WAIT  = 5;
  localparam logic [7:0] MC0_RESET = 8'h01;
  // rx flag bits: wake, rx warn, tx warn, rx passive, tx passive, busoff, overrun, rx full
  localparam int RF_WAKE = 7;
  localparam int RF_RWRN = 6;
  localparam int RF_TWRN = 5;
  localparam int RF_RPAS = 4;
  localparam int RF_TPAS = 3;
  localparam int RF_BOFF = 2;
  localparam int RF_OVR  = 1;
  localparam int RF_RXF  = 0;
  localparam logic [7:0] ERR_MASK = 8'h7e;
  localparam logic [2:0] TXE_RESET = 3'h7;
  // acceptance ctrl fields
  localparam int AC_MODE_LSB = 4;
  localparam int AC_HIT_W    = 3;
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0ff;
  typedef enum logic [1:0] {FM_TWO, FM_FOUR, FM_EIGHT, FM_CLOSED} cfl_fmode_t;
  typedef enum logic [1:0] {MD_NORMAL, MD_SLEEP, MD_SOFTRST, MD_PWRDN} cfl_pmode_t;
endpackage

// file: verif/cfl_node_model.sv
// behavioural CAN engine and transceiver side feeding the filter block
`timescale 1ns/10ps
module cfl_node_model (
  input  wire logic        clk,          // controller clock
  input  wire logic        engineClkEn,  // frames complete only while engine clocked
  output logic      [31:0] rxIdBits,     // id bits, valid with frame done
  output logic             rxFrameDone,  // one cycle after end of frame
  output logic             rxOwnFrame,   // frame was our own transmission
  output logic             bgBufFull,    // background buffer occupied
  output logic      [8:0]  rxErrCount,   // receive error counter
  output logic      [8:0]  txErrCount,   // transmit error counter
  output logic             busActivity,  // bus edges seen
  output logic             sleepGranted, // engine idle, may sleep
  output logic      [2:0]  txEmptySet,   // buffers released
  output logic             engineTx      // engine bit, 1 recessive
);
  initial begin
    rxIdBits = 32'h5a5a_a5a5;
    {rxFrameDone, rxOwnFrame, bgBufFull, busActivity, sleepGranted} = 5'h00;
    {rxErrCount, txErrCount, txEmptySet} = 21'h0;
    engineTx = 1'b1;
  end
  task automatic frame(logic [31:0] id, logic own);
    @(posedge clk);
    // a halted engine completes no frame
    if (engineClkEn === 1'b1) begin
      rxIdBits <= id;
      rxFrameDone <= 1'b1;
      rxOwnFrame <= own;
      @(posedge clk);
      rxFrameDone <= 1'b0;
      rxOwnFrame <= 1'b0;
      // id lines no longer valid, so never leave the old value
      rxIdBits <= ~id;
    end
  endtask
  task automatic lvl(logic bg, logic act, logic slp, logic tx);
    @(posedge clk);
    bgBufFull <= bg;
    busActivity <= act;
    sleepGranted <= slp;
    engineTx <= tx;
  endtask
  task automatic err(logic [8:0] r, logic [8:0] t);
    @(posedge clk);
    rxErrCount <= r;
    txErrCount <= t;
  endtask
  task automatic txDone(logic [2:0] m);
    @(posedge clk);
    txEmptySet <= m;
    @(posedge clk);
    txEmptySet <= 3'h0;
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the CAN filter, flag and low-power block
`timescale 1ns/10ps
module testbench;
  import cfl_pkg::*;
  typedef struct {logic [1:0] m; logic [63:0] c, k; logic [31:0] id;
                  logic acc; logic [2:0] hit;} cfl_row_t;
  logic        clk, rst_n, avsRead, avsWrite, cpuStop, cpuWait, rxFrameDone, rxOwnFrame;
  logic        bgBufFull, busActivity, sleepGranted, engineTx, avsWaitRequest, canTxPin;
  logic        engineClkEn, regClkEn, fgLoad, wakeIrq, errIrq, rxIrq, txIrq;
  logic [2:0]  txEmptySet;
  logic [3:0]  avsByteEnable;
  logic [4:0]  avsAddress;
  logic [8:0]  rxErrCount, txErrCount;
  logic [31:0] avsWriteData, avsReadData, rxIdBits, rd;
  int          errors, num_checks, loads, n0;
  cfl_row_t    rows [9] = '{
    '{2'd0, 64'h12345678_9abcdef0, 64'h0, 32'h9abcdef0, 1'b1, 3'd1},
    '{2'd0, 64'h12345678_12345678, 64'h0, 32'h12345678, 1'b1, 3'd0},
    '{2'd0, 64'h00000000_11111111, 64'h0000000f_00000000, 32'h00000005, 1'b1, 3'd0},
    '{2'd0, 64'h00000000_11111111, 64'h0000000f_00000000, 32'h00000015, 1'b0, 3'd0},
    '{2'd1, 64'h11112222_33334444, 64'h0, 32'h3333abcd, 1'b1, 3'd2},
    '{2'd1, 64'h11112222_33334444, 64'h0, 32'h44440000, 1'b1, 3'd3},
    '{2'd2, 64'h00010203_04050607, 64'h0, 32'h05ffffff, 1'b1, 3'd5},
    '{2'd2, 64'h00010203_04050607, 64'h000000ff_00000000, 32'h09000000, 1'b1, 3'd3},
    '{2'd3, 64'h12345678_12345678, 64'h0, 32'h12345678, 1'b0, 3'd0}};
  int          eRx [8] = '{95, 96, 0, 127, 128, 0, 0, 0};
  int          eTx [8] = '{0, 0, 96, 0, 0, 128, 255, 256};
  int          eBit [8] = '{RF_RWRN, RF_RWRN, RF_TWRN, RF_RPAS, RF_RPAS, RF_TPAS, RF_BOFF, RF_BOFF};
  logic [7:0]  eExp = 8'b10110110;
  logic [4:0]  lockA [5] = '{OFF_MODULE_CTRL1, OFF_BIT_TIMING0, OFF_BIT_TIMING1, OFF_ACC_CODE0,
                             5'h1f};

  cfl_ctrl dut (.clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
    .avsReadData, .avsWaitRequest, .rxIdBits, .rxFrameDone, .rxOwnFrame, .bgBufFull,
    .rxErrCount, .txErrCount, .busActivity, .sleepGranted, .txEmptySet, .cpuStop, .cpuWait,
    .engineTx, .canTxPin, .engineClkEn, .regClkEn, .fgLoad, .wakeIrq, .errIrq, .rxIrq, .txIrq);
  cfl_node_model node (.clk, .engineClkEn, .rxIdBits, .rxFrameDone, .rxOwnFrame, .bgBufFull,
    .rxErrCount, .txErrCount, .busActivity, .sleepGranted, .txEmptySet, .engineTx);

  always #12.5 clk = ~clk;
  always @(posedge clk) if (fgLoad === 1'b1) loads++;

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chkW(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkB(string n, logic e, logic g);
    chkW(n, {31'h0, e}, {31'h0, g});
  endtask
  // held until waitrequest is sampled low, then released at that edge
  task automatic bus(logic w, logic [4:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= {24'h0, d};
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    chkB("answer", 1'b0, avsWaitRequest);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic setup(logic [1:0] m, logic [63:0] c, logic [63:0] k);
    wr(OFF_MODULE_CTRL0, 8'h01);
    wr(OFF_ID_ACC_CTRL, {2'h0, m, 4'h0});
    for (int i = 0; i < 8; i++) begin
      wr(OFF_ACC_CODE0 + 5'(i), c[63-8*i -: 8]);
      wr(OFF_ACC_MASK0 + 5'(i), k[63-8*i -: 8]);
    end
    wr(OFF_MODULE_CTRL0, 8'h00);
  endtask

  initial begin
    #(25ns * 20000);
    errors++;
    conclude();
  end

  initial begin
    {clk, rst_n, avsRead, avsWrite, cpuStop, cpuWait} = 6'h0;
    avsAddress = 5'h00;
    avsWriteData = 32'h0;
    avsByteEnable = 4'h1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chkB("resetPin", 1'b1, canTxPin);
    chkB("resetEngClk", 1'b0, engineClkEn);
    bus(1'b0, OFF_MODULE_CTRL0, 8'h00);
    chkW("ctrl0", {24'h0, MC0_RESET}, rd);
    bus(1'b0, OFF_TX_FLAG, 8'h00);
    chkW("txFlags", {29'h0, TXE_RESET}, {29'h0, rd[2:0]});
    wr(5'h0c, 8'hff);
    bus(1'b0, 5'h0c, 8'h00);
    chkW("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      setup(rows[i].m, rows[i].c, rows[i].k);
      wr(OFF_RX_IRQ_EN, 8'h01);
      n0 = loads;
      node.frame(rows[i].id, 1'b0);
      repeat (2) @(posedge clk);
      chkB("rxIrq", rows[i].acc, rxIrq);
      chkW("loads", {31'h0, rows[i].acc}, loads - n0);
      bus(1'b0, OFF_RX_FLAG, 8'h00);
      chkB("rxFull", rows[i].acc, rd[RF_RXF]);
      bus(1'b0, OFF_ID_ACC_CTRL, 8'h00);
      chkW("mode", {30'h0, rows[i].m}, {30'h0, rd[5:4]});
      if (rows[i].acc) chkW("hit", {29'h0, rows[i].hit}, {29'h0, rd[2:0]});
      wr(OFF_RX_FLAG, 8'h01);
      repeat (2) @(posedge clk);
      chkB("rxIrqClr", 1'b0, rxIrq);
    end
    wr(OFF_MODULE_CTRL0, 8'h01);
    foreach (lockA[j]) wr(lockA[j], 8'ha5);
    wr(OFF_MODULE_CTRL0, 8'h00);
    wr(OFF_ID_ACC_CTRL, 8'h00);
    foreach (lockA[j]) begin
      wr(lockA[j], 8'h5a);
      bus(1'b0, lockA[j], 8'h00);
      chkW("locked", 32'ha5, {24'h0, rd[7:0]});
    end
    bus(1'b0, OFF_ID_ACC_CTRL, 8'h00);
    chkW("modeLocked", 32'h3, {30'h0, rd[5:4]});
    for (int j = 0; j < 8; j++) begin
      wr(OFF_RX_IRQ_EN, 8'(1 << eBit[j]));
      node.err(9'(eRx[j]), 9'(eTx[j]));
      repeat (3) @(posedge clk);
      chkB("errIrq", eExp[j], errIrq);
      bus(1'b0, OFF_RX_FLAG, 8'h00);
      chkB("errFlag", eExp[j], rd[eBit[j]]);
      node.err(9'h0, 9'h0);
      wr(OFF_RX_FLAG, 8'h7e);
    end
    node.err(9'h060, 9'h105);
    repeat (3) @(posedge clk);
    wr(OFF_RX_FLAG, 8'h40);
    wr(OFF_ERR_COUNT, 8'hff);
    bus(1'b0, OFF_RX_FLAG, 8'h00);
    chkB("warnHeld", 1'b1, rd[RF_RWRN]);
    bus(1'b0, OFF_ERR_COUNT, 8'h00);
    chkW("errCount", 32'h0105_0060, rd);
    node.err(9'h0, 9'h0);
    wr(OFF_RX_FLAG, 8'h7e);
    wr(OFF_TX_CTRL, 8'h02);
    repeat (2) @(posedge clk);
    chkB("txIrq", 1'b1, txIrq);
    wr(OFF_TX_FLAG, 8'h07);
    repeat (2) @(posedge clk);
    chkB("txIrqClr", 1'b0, txIrq);
    node.txDone(3'b100);
    repeat (2) @(posedge clk);
    chkB("txIrqMasked", 1'b0, txIrq);
    node.txDone(3'b010);
    repeat (2) @(posedge clk);
    chkB("txIrqSet", 1'b1, txIrq);
    bus(1'b0, OFF_TX_FLAG, 8'h00);
    chkW("txFlagsSet", 32'h6, {29'h0, rd[2:0]});
    setup(2'd0, 64'h0, '1);
    wr(OFF_RX_IRQ_EN, 8'h02);
    n0 = loads;
    node.frame(32'h1, 1'b1);
    node.frame(32'h2, 1'b0);
    node.lvl(1'b1, 1'b0, 1'b0, 1'b0);
    node.frame(32'h3, 1'b0);
    repeat (2) @(posedge clk);
    chkW("ovrLoads", 32'h1, loads - n0);
    chkB("ovrIrq", 1'b1, errIrq);
    bus(1'b0, OFF_RX_FLAG, 8'h00);
    chkW("ovrFlags", 32'h3, {30'h0, rd[1:0]});
    node.lvl(1'b0, 1'b1, 1'b0, 1'b0);
    wr(OFF_RX_FLAG, 8'h03);
    wr(OFF_RX_IRQ_EN, 8'h80);
    chkB("pinNormal", 1'b0, canTxPin);
    bus(1'b0, OFF_RX_FLAG, 8'h00);
    chkB("wakeNormal", 1'b0, rd[RF_WAKE]);
    node.lvl(1'b0, 1'b0, 1'b1, 1'b0);
    wr(OFF_MODULE_CTRL0, 8'h02);
    repeat (3) @(posedge clk);
    bus(1'b0, OFF_MODULE_CTRL0, 8'h00);
    chkB("sleepAck", 1'b1, rd[MC0_SLEEP_ACK]);
    chkB("pinSleep", 1'b1, canTxPin);
    chkB("engClkSleep", 1'b0, engineClkEn);
    chkB("regClkSleep", 1'b1, regClkEn);
    node.lvl(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chkB("wakeIrq", 1'b1, wakeIrq);
    node.lvl(1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFF_RX_FLAG, 8'h80);
    wr(OFF_MODULE_CTRL0, 8'h01);
    repeat (2) @(posedge clk);
    chkB("wakeClr", 1'b0, wakeIrq);
    chkB("pinSoftRst", 1'b1, canTxPin);
    wr(OFF_MODULE_CTRL0, 8'h20);
    cpuWait <= 1'b1;
    repeat (2) @(posedge clk);
    chkB("regClkDown", 1'b0, regClkEn);
    chkB("pinDown", 1'b1, canTxPin);
    fork
      bus(1'b0, OFF_MODULE_CTRL0, 8'h00);
      begin
        repeat (5) @(posedge clk);
        chkB("downWait", 1'b1, avsWaitRequest);
        cpuWait <= 1'b0;
      end
    join
    chkW("ctrl0Wait", 32'h20, {26'h0, rd[5:0]});
    wr(OFF_MODULE_CTRL0, 8'h00);
    cpuWait <= 1'b1;
    repeat (2) @(posedge clk);
    chkB("engClkWait", 1'b1, engineClkEn);
    cpuWait <= 1'b0;
    cpuStop <= 1'b1;
    repeat (2) @(posedge clk);
    chkB("regClkStop", 1'b0, regClkEn);
    cpuStop <= 1'b0;
    conclude();
  end
endmodule
